// File: design/adcc_regs.svh
// register map, field positions and timing counts of the converter control block
// What this block does
// [RULE1] enable bit zero keeps converter idle
// [RULE2] full resolution stores ten-bit sample
// [RULE3] reduced resolution drops two low bits
// [RULE4] free running restarts after each completion
// [RULE5] software starts first free-running conversion
// [RULE6] standby run bit gates operation asleep
// [RULE7] accumulation code selects 1 to 64
// [RULE8] sum all samples, then complete once
// [RULE9] capacitor select bit drives sample cap
// [RULE10] reference code picks internal or supply
// [RULE11] converter clock divides by 2 to 256
// [RULE12] start-up delay after enable or reference
// [RULE13] start-up delay after deep sleep wake
// [RULE14] init codes give 0 to 256 cycles
// [RULE15] auto variation increments spacing each sample
// [RULE16] spacing wraps from fifteen to zero
// [RULE17] spacing cycles wait between samples
// [RULE18] sample switch open during spacing
// [RULE19] start bit reads one while converting
// [RULE20] window check once after last sample
// [RULE21] sampling lasts two plus length cycles
// [RULE22] sum right-justified, cleared per sequence
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
`define ADCC_IX_CONTROL_A 6'h00
`define ADCC_IX_CONTROL_B 6'h01
`define ADCC_IX_CONTROL_C 6'h02
`define ADCC_IX_CONTROL_D 6'h03
`define ADCC_IX_CONTROL_E 6'h04
`define ADCC_IX_SAMPLE_CONTROL 6'h05
`define ADCC_IX_INPUT_SELECT 6'h06
`define ADCC_IX_COMMAND 6'h08
`define ADCC_IX_EVENT_CONTROL 6'h09
`define ADCC_IX_IRQ_ENABLE 6'h0a
`define ADCC_IX_IRQ_FLAGS 6'h0b
`define ADCC_IX_DEBUG_CONTROL 6'h0c
`define ADCC_IX_TEMP_SCRATCH 6'h0d
`define ADCC_IX_RESULT 6'h10
`define ADCC_IX_WINDOW_LOW 6'h12
`define ADCC_IX_WINDOW_HIGH 6'h14
`define ADCC_IX_CALIBRATION 6'h16
`define ADCC_A_ENABLE 0
`define ADCC_A_FREE 1
`define ADCC_A_RES 2
`define ADCC_A_STBY 7
`define ADCC_A_MASK 8'h87
`define ADCC_B_ACC 2:0
`define ADCC_C_CAP 6
`define ADCC_C_REF 5:4
`define ADCC_C_DIV 2:0
`define ADCC_C_MASK 8'h77
`define ADCC_D_INIT 7:5
`define ADCC_D_AUTO_DELAY_VARIATION 4
`define ADCC_D_SPACE 3:0
`define ADCC_E_WIN 2:0
`define ADCC_LEN 4:0
`define ADCC_F_RDY 0
`define ADCC_F_WIN 1
`define ADCC_REF_INTERNAL 2'h0
`define ADCC_ACC_RESERVED 3'h7
`define ADCC_INIT_MAX 3'h5
`define ADCC_INIT_UNIT 9'h008
`define ADCC_SAMPLE_BASE 9'h002
`define ADCC_PHASE_GUARD 9'h001
`define ADCC_RESET8 8'h00
`define ADCC_RESET16 16'h0000
`endif

// File: design/adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_INIT = 5'b00010,
    S_SAMP = 5'b00100,
    S_CONV = 5'b01000,
    S_SPACE = 5'b10000
  } adcc_state_t;
  typedef enum logic [2:0] {
    W_NONE = 3'h0,
    W_BELOW = 3'h1,
    W_ABOVE = 3'h2,
    W_INSIDE = 3'h3,
    W_OUTSIDE = 3'h4
  } adcc_win_t;
endpackage : adcc_pkg

// File: design/adcc_clkdiv.sv
// converter clock enable: one pulse every 2^(sel+1) clocks
module adcc_clkdiv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [7:0] cnt;
  wire [7:0] mask = 8'((9'h002 << sel) - 9'h001);
  wire hit = (cnt & mask) == mask;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      tick <= hit; // [RULE11]
    end
  end
endmodule : adcc_clkdiv

// File: design/adcc_down.sv
// loadable down counter stepped by converter clock ticks
module adcc_down #(parameter int W = 9) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] val,
  input wire logic step,
  output logic zero
);
  logic [W-1:0] cnt;
  assign zero = cnt == '0;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (load)
      cnt <= val;
    else if (step && !zero)
      cnt <= cnt - W'(1);
  end
endmodule : adcc_down

// File: design/adcc_top.sv
// converter control: register file, sequencer, accumulator and window check
`include "adcc_regs.svh"
module adcc_top
  import adcc_pkg::*;
#(
  parameter int DW = 10,
  parameter int RW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic standby,
  input wire logic debug_halt,
  input wire logic wake_pulse,
  input wire logic start_event,
  input wire logic conv_done,
  input wire logic [DW-1:0] conv_data,
  output logic core_enable,
  output logic sample_close,
  output logic convert_req,
  output logic [1:0] ref_sel,
  output logic cap_sel,
  output logic [4:0] mux_sel
);
  logic [7:0] control_a, control_b, control_c, control_d, control_e;
  logic [7:0] sample_control, input_select, event_control, irq_enable;
  logic [7:0] irq_flags, debug_control, temp_scratch, calibration;
  logic [RW-1:0] result, window_low, window_high, acc;
  logic start_conversion, need_init, event_q;
  logic [6:0] samp_cnt;
  adcc_state_t st, next_st;
  logic cnt_load;
  logic [8:0] cnt_val;
  logic [31:0] rd_mux;
  wire tick, cnt_zero;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [5:0] idx = wb_adr_i[7:2];
  wire wr_lo = req & wb_we_i & wb_sel_i[0];
  wire wr_hi = req & wb_we_i & wb_sel_i[1];
  wire [7:0] wd = wb_dat_i[7:0];
  wire w_a = wr_lo && idx == `ADCC_IX_CONTROL_A;
  wire w_c = wr_lo && idx == `ADCC_IX_CONTROL_C;
  wire w_d = wr_lo && idx == `ADCC_IX_CONTROL_D;
  wire w_cmd = wr_lo && idx == `ADCC_IX_COMMAND && wd[0];
  wire w_flg = wr_lo && idx == `ADCC_IX_IRQ_FLAGS;

  // run conditions: standby and debug halt hold the timed states and block new starts; a requested conversion still completes
  wire enabled = control_a[`ADCC_A_ENABLE];
  wire run = enabled && !(standby && !control_a[`ADCC_A_STBY]) && !(debug_halt && !debug_control[0]); // [RULE1] [RULE6]
  wire adv = tick & run;

  // sample shaping and accumulation
  wire [RW-1:0] samp_full = RW'(conv_data); // [RULE2]
  wire [RW-1:0] samp_trunc = RW'(conv_data[DW-1:2]); // [RULE3]
  wire [RW-1:0] samp_val = control_a[`ADCC_A_RES] ? samp_trunc : samp_full;
  wire [2:0] acc_code = control_b[`ADCC_B_ACC] == `ADCC_ACC_RESERVED ? 3'h0 : control_b[`ADCC_B_ACC];
  wire [6:0] acc_last = 7'((8'h01 << acc_code) - 8'h01); // [RULE7]
  wire first = samp_cnt == 7'h00;
  wire [RW-1:0] acc_next = (first ? `ADCC_RESET16 : acc) + samp_val; // [RULE22]
  // a sample that lands as the block is switched off is dropped, not half stored
  wire got = st == S_CONV && conv_done && enabled;
  wire last = samp_cnt == acc_last;
  wire done_last = got && last; // [RULE8]

  // window comparison on the finished sum only
  wire lt = acc_next < window_low;
  wire gt = acc_next > window_high;
  wire win_hit = control_e[`ADCC_E_WIN] == W_BELOW ? lt :
                 control_e[`ADCC_E_WIN] == W_ABOVE ? gt :
                 control_e[`ADCC_E_WIN] == W_INSIDE ? (!lt && acc_next != window_low && !gt && acc_next != window_high) :
                 control_e[`ADCC_E_WIN] == W_OUTSIDE ? (lt || gt) : 1'b0;
  wire set_win = done_last && win_hit; // [RULE20]

  // delays in converter clock cycles
  wire [2:0] init_code = control_d[`ADCC_D_INIT];
  wire [8:0] init_len = (init_code == 3'h0 || init_code > `ADCC_INIT_MAX) ? 9'h000 : 9'(`ADCC_INIT_UNIT << init_code); // [RULE14]
  // one guard tick: the divider phase is free, so the first tick may come one clock after the load
  wire [8:0] samp_len = `ADCC_SAMPLE_BASE + 9'(sample_control[`ADCC_LEN]) + `ADCC_PHASE_GUARD; // [RULE21]
  wire [8:0] space_len = 9'(control_d[`ADCC_D_SPACE]); // [RULE17]
  wire ev_rise = start_event && !event_q && event_control[0];

  adcc_clkdiv u_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(enabled),
    .sel(control_c[`ADCC_C_DIV]),
    .tick(tick)
  );

  adcc_down #(.W(9)) u_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .load(cnt_load),
    .val(cnt_val),
    .step(adv),
    .zero(cnt_zero)
  );

  // sequencer
  always_comb
  begin
    next_st = st;
    cnt_load = 1'b0;
    cnt_val = samp_len;
    case (st)
      S_IDLE:
        if (start_conversion && run)
        begin
          cnt_load = 1'b1;
          next_st = need_init ? S_INIT : S_SAMP; // [RULE12] [RULE13]
          cnt_val = need_init ? init_len : samp_len;
        end
      S_INIT:
        if (cnt_zero)
        begin
          cnt_load = 1'b1;
          next_st = S_SAMP;
        end
      S_SAMP:
        if (cnt_zero)
          next_st = S_CONV;
      S_CONV:
        if (conv_done)
        begin
          cnt_load = 1'b1;
          next_st = last ? S_IDLE : S_SPACE; // [RULE4]
          cnt_val = space_len;
        end
      S_SPACE:
        if (cnt_zero)
        begin
          cnt_load = 1'b1;
          next_st = S_SAMP;
        end
      default:
        next_st = S_IDLE;
    endcase
    if (!enabled)
      next_st = S_IDLE; // [RULE1]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= S_IDLE;
      sample_close <= 1'b0;
      convert_req <= 1'b0;
      core_enable <= 1'b0;
      event_q <= 1'b0;
    end
    else
    begin
      st <= next_st;
      sample_close <= next_st == S_SAMP; // [RULE18]
      convert_req <= next_st == S_CONV;
      core_enable <= run; // [RULE1] [RULE6]
      event_q <= start_event;
    end
  end

  // accumulation and result
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc <= `ADCC_RESET16;
      result <= `ADCC_RESET16;
      samp_cnt <= 7'h00;
    end
    else if (!enabled)
      samp_cnt <= 7'h00;
    else if (got)
    begin
      acc <= acc_next;
      samp_cnt <= last ? 7'h00 : samp_cnt + 7'h01;
      if (last)
        result <= acc_next; // [RULE8]
    end
  end

  // start bit: a new start outranks the completion clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      start_conversion <= 1'b0;
    else if ((w_cmd || ev_rise) && enabled)
      start_conversion <= 1'b1; // [RULE19] [RULE5]
    else if (!enabled || (done_last && !control_a[`ADCC_A_FREE]))
      start_conversion <= 1'b0; // [RULE19]
  end

  // start-up delay request; a new cause outranks the clear on entry
  wire init_cause = (w_a && wd[`ADCC_A_ENABLE] && !enabled) || wake_pulse ||
                    (w_c && wd[5:4] == `ADCC_REF_INTERNAL && control_c[`ADCC_C_REF] != `ADCC_REF_INTERNAL);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      need_init <= 1'b1;
    else if (init_cause)
      need_init <= 1'b1; // [RULE12] [RULE13]
    else if (st == S_IDLE && next_st == S_INIT)
      need_init <= 1'b0;
  end

  // flags: hardware set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_flags <= `ADCC_RESET8;
    else
    begin
      irq_flags[`ADCC_F_RDY] <= done_last || (irq_flags[`ADCC_F_RDY] && !(w_flg && wd[`ADCC_F_RDY])); // [RULE4]
      irq_flags[`ADCC_F_WIN] <= set_win || (irq_flags[`ADCC_F_WIN] && !(w_flg && wd[`ADCC_F_WIN]));
    end
  end

  // sample spacing: software write outranks the automatic step
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      control_d <= `ADCC_RESET8;
    else if (w_d)
      control_d <= wd;
    else if (got && control_d[`ADCC_D_AUTO_DELAY_VARIATION])
      control_d[`ADCC_D_SPACE] <= control_d[`ADCC_D_SPACE] + 4'h1; // [RULE15] [RULE16]
  end

  // plain configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {control_a, control_b, control_c, control_e} <= {4{`ADCC_RESET8}};
      {sample_control, input_select, event_control, irq_enable} <= {4{`ADCC_RESET8}};
      {debug_control, temp_scratch, calibration} <= {3{`ADCC_RESET8}};
      {window_low, window_high} <= {2{`ADCC_RESET16}};
    end
    else if (wr_lo || wr_hi)
      case (idx)
        `ADCC_IX_CONTROL_A: if (wr_lo) control_a <= wd & `ADCC_A_MASK;
        `ADCC_IX_CONTROL_B: if (wr_lo) control_b <= {5'h00, wd[2:0]};
        `ADCC_IX_CONTROL_C: if (wr_lo) control_c <= wd & `ADCC_C_MASK; // [RULE9] [RULE10] [RULE11]
        `ADCC_IX_CONTROL_E: if (wr_lo) control_e <= {5'h00, wd[2:0]};
        `ADCC_IX_SAMPLE_CONTROL: if (wr_lo) sample_control <= {3'h0, wd[4:0]};
        `ADCC_IX_INPUT_SELECT: if (wr_lo) input_select <= {3'h0, wd[4:0]};
        `ADCC_IX_EVENT_CONTROL: if (wr_lo) event_control <= {7'h00, wd[0]};
        `ADCC_IX_IRQ_ENABLE: if (wr_lo) irq_enable <= {6'h00, wd[1:0]};
        `ADCC_IX_DEBUG_CONTROL: if (wr_lo) debug_control <= {7'h00, wd[0]};
        `ADCC_IX_TEMP_SCRATCH: if (wr_lo) temp_scratch <= wd;
        `ADCC_IX_CALIBRATION: if (wr_lo) calibration <= {7'h00, wd[0]};
        `ADCC_IX_WINDOW_LOW:
        begin
          if (wr_lo) window_low[7:0] <= wd;
          if (wr_hi) window_low[15:8] <= wb_dat_i[15:8];
        end
        `ADCC_IX_WINDOW_HIGH:
        begin
          if (wr_lo) window_high[7:0] <= wd;
          if (wr_hi) window_high[15:8] <= wb_dat_i[15:8];
        end
        default: ;
      endcase
  end

  // analog settings come straight from register flops; input select is
  // taken only between conversions so a change mid-conversion waits
  assign ref_sel = control_c[`ADCC_C_REF]; // [RULE10]
  assign cap_sel = control_c[`ADCC_C_CAP]; // [RULE9]
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mux_sel <= 5'h00;
    else if (st == S_IDLE)
      mux_sel <= input_select[4:0];
  end

  // read mux; unmapped words read zero and still acknowledge
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `ADCC_IX_CONTROL_A: rd_mux[7:0] = control_a;
      `ADCC_IX_CONTROL_B: rd_mux[7:0] = control_b;
      `ADCC_IX_CONTROL_C: rd_mux[7:0] = control_c;
      `ADCC_IX_CONTROL_D: rd_mux[7:0] = control_d;
      `ADCC_IX_CONTROL_E: rd_mux[7:0] = control_e;
      `ADCC_IX_SAMPLE_CONTROL: rd_mux[7:0] = sample_control;
      `ADCC_IX_INPUT_SELECT: rd_mux[7:0] = input_select;
      `ADCC_IX_COMMAND: rd_mux[0] = start_conversion; // [RULE19]
      `ADCC_IX_EVENT_CONTROL: rd_mux[7:0] = event_control;
      `ADCC_IX_IRQ_ENABLE: rd_mux[7:0] = irq_enable;
      `ADCC_IX_IRQ_FLAGS: rd_mux[7:0] = irq_flags;
      `ADCC_IX_DEBUG_CONTROL: rd_mux[7:0] = debug_control;
      `ADCC_IX_TEMP_SCRATCH: rd_mux[7:0] = temp_scratch;
      `ADCC_IX_RESULT: rd_mux[15:0] = result;
      `ADCC_IX_WINDOW_LOW: rd_mux[15:0] = window_low;
      `ADCC_IX_WINDOW_HIGH: rd_mux[15:0] = window_high;
      `ADCC_IX_CALIBRATION: rd_mux[7:0] = calibration;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req)
        wb_dat_o <= rd_mux;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_off_idle: assert property (!enabled |=> st == S_IDLE && !convert_req) // [RULE1]
    else $error("sequencer active while disabled");
  a_full_store: assert property (done_last && first && !control_a[`ADCC_A_RES]
    |=> result == RW'($past(conv_data))) // [RULE2]
    else $error("full resolution result wrong");
  a_trunc_store: assert property (done_last && first && control_a[`ADCC_A_RES]
    |=> result == RW'($past(conv_data[DW-1:2]))) // [RULE3]
    else $error("truncated result wrong");
  a_start_clear: assert property (done_last && !control_a[`ADCC_A_FREE] && !w_cmd && !ev_rise
    |=> !start_conversion && irq_flags[`ADCC_F_RDY]) // [RULE19]
    else $error("start bit not cleared at completion");
  a_space_open: assert property (st == S_SPACE |-> !sample_close) // [RULE18]
    else $error("sample switch closed in spacing");
  a_auto_step: assert property (got && control_d[`ADCC_D_AUTO_DELAY_VARIATION] && !w_d
    |=> control_d[3:0] == 4'($past(control_d[3:0]) + 4'h1)) // [RULE15]
    else $error("spacing not stepped");
  a_samp_hold: assert property (st == S_SAMP && !cnt_zero && enabled |=> st == S_SAMP) // [RULE21]
    else $error("sampling cut short");
  a_init_first: assert property (st == S_IDLE && next_st == S_SAMP |-> !need_init) // [RULE12]
    else $error("start-up delay skipped");
  a_win_once: assert property ($rose(irq_flags[`ADCC_F_WIN]) |-> $past(done_last)) // [RULE20]
    else $error("window flag before last sample");
  a_tick_gap: assert property (tick |=> !tick) // [RULE11]
    else $error("converter clock faster than half rate");
endmodule : adcc_top

// File: tb/adcc_core_model.sv
// behavioural converter core that answers sample requests after a random wait
module adcc_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic convert_req,
  input wire logic [9:0] sample_val,
  output logic conv_done,
  output logic [9:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_n;
  // data toggles outside the done pulse so a stale sample is never mistaken for a fresh one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      conv_done <= 1'b0;
      conv_data <= 10'h000;
      wait_n <= 2'h0;
    end
    else if (convert_req && !conv_done && wait_n == 2'h0)
    begin
      conv_done <= 1'b1;
      conv_data <= sample_val;
      wait_n <= 2'($urandom);
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (convert_req && wait_n != 2'h0)
        wait_n <= wait_n - 2'h1;
    end
  end
endmodule : adcc_core_model

// File: tb/testbench.sv
// self-checking bench for the converter control block
module testbench;
  import adcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cyc, stb, we, stby, wake, ev, ack, core_en, close, creq, cap, done, close_q;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, r, e;
  logic [1:0] ref_s;
  logic [4:0] mux;
  logic [9:0] sval, cdata;
  int miscompares, checks_done, cyc_n, rise_at, gap, hi_len, t0, done_at, p, n;
  logic [7:0] adrs [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24, 8'h28, 8'h34, 8'h48, 8'h1c};
  logic [31:0] msk [12] = '{32'h87, 32'h07, 32'h77, 32'hff, 32'h07, 32'h1f, 32'h1f, 32'h01, 32'h03, 32'hff,
    32'hffff, 32'h0};
  adcc_top u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .standby(stby), .debug_halt(1'b0),
    .wake_pulse(wake), .start_event(ev), .conv_done(done), .conv_data(cdata), .core_enable(core_en),
    .sample_close(close), .convert_req(creq), .ref_sel(ref_s), .cap_sel(cap), .mux_sel(mux));
  adcc_core_model u_core (.clk(clk), .rst_n(rst_n), .convert_req(creq), .sample_val(sval), .conv_done(done),
    .conv_data(cdata));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // phase timing is measured here so the checks do not depend on bus polling
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    close_q <= close;
    if (done)
      done_at <= cyc_n;
    if (close && !close_q)
    begin
      rise_at <= cyc_n;
      gap <= cyc_n - done_at;
    end
    if (!close && close_q)
      hi_len <= cyc_n - rise_at;
    if (cyc_n == 60000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic chk_in(input string nm, input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi)
    begin
      miscompares++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : chk_in
  // the request is held until ack is sampled, so a slow answer never truncates it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    do @(posedge clk); while (ack !== 1'b1);
    rq = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dq;
    xfer(1'b1, a, d, dq);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    xfer(1'b0, a, 32'h0, rq);
  endtask : rd
  task automatic wait_rdy();
    logic [31:0] fq;
    int i;
    fq = 32'h0;
    for (i = 0; i < 4000 && fq[0] !== 1'b1; i++)
      rd(8'h2c, fq);
    wr(8'h2c, 32'h1);
  endtask : wait_rdy
  task automatic conv(input logic [9:0] v);
    sval <= v;
    wr(8'h20, 32'h1);
    t0 = cyc_n;
    wait_rdy();
  endtask : conv
  function automatic logic [31:0] exp_res(input logic [9:0] v, input logic rs, input logic [2:0] k);
    logic [31:0] s;
    s = rs ? {24'h0, v[9:2]} : {22'h0, v};
    return (k == 3'h7) ? s : s << k;
  endfunction : exp_res
  initial
  begin
    {rst_n, cyc, stb, we, stby, wake, ev} = 7'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    sval = 10'h000;
    r = $urandom(32'h50c2);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (adrs[i])
    begin
      rd(adrs[i], q);
      chk("reset value", 32'h0, q);
      r = $urandom;
      wr(adrs[i], r);
      rd(adrs[i], q);
      chk("readback", r & msk[i], q);
      if (i == 2)
        chk("ref and cap", {29'h0, r[6:4]}, {29'h0, cap, ref_s});
      if (i == 6)
        chk("input select", r & 32'h1f, {27'h0, mux});
      wr(adrs[i], 32'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, {29'h0, i[0], 2'b01});
      r = $urandom;
      e = exp_res(r[9:0], i[0], 3'h0);
      sval <= r[9:0];
      wr(8'h20, 32'h1);
      rd(8'h20, q);
      chk("start busy", 32'h1, q);
      wait_rdy();
      rd(8'h20, q);
      chk("start done", 32'h0, q);
      sval <= 10'($urandom);
      rd(8'h40, q);
      chk("result", e, q);
    end
    wr(8'h40, 32'hffff);
    rd(8'h40, q);
    chk("result write", e, q);
    wr(8'h00, 32'h1);
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h04, 32'(k));
      r = 32'($urandom % 1024);
      conv(r[9:0]);
      rd(8'h40, q);
      chk("sum", exp_res(r[9:0], 1'b0, 3'(k)), q);
    end
    wr(8'h04, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h0c, 32'(k << 5));
      if (k[0])
      begin
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
      end
      else
      begin
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h1);
      end
      n = (k == 0) ? 0 : (8 << k);
      conv(10'h155);
      chk_in("start-up delay", rise_at - t0, n * 2, n * 2 + 8);
    end
    conv(10'h0aa);
    chk_in("no start-up delay", rise_at - t0, 0, 8);
    wr(8'h0c, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 0) ? 32'h7 : 32'($urandom % 4);
      n = $urandom % 4;
      p = 2 << r;
      wr(8'h08, r);
      wr(8'h14, 32'(n));
      conv(10'h3ff);
      chk_in("sample length", hi_len, (2 + n) * p - 1, (3 + n) * p + 1);
    end
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h1);
    n = 1 + $urandom % 15;
    wr(8'h0c, 32'(n));
    conv(10'h123);
    chk_in("spacing", gap, n * 2, n * 2 + 6);
    wr(8'h0c, 32'h1f);
    conv(10'h321);
    rd(8'h0c, q);
    chk("auto spacing", 32'h11, q);
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h24, 32'h1);
    sval <= 10'h2c7;
    ev <= 1'b1;
    wait_rdy();
    ev <= 1'b0;
    rd(8'h40, q);
    chk("event result", 32'h2c7, q);
    wr(8'h24, 32'h0);
    wr(8'h48, 32'h100);
    wr(8'h10, 32'h1);
    wr(8'h04, 32'h1);
    conv(10'h090);
    rd(8'h2c, q);
    chk("window on sum only", 32'h0, q);
    conv(10'h07f);
    rd(8'h2c, q);
    chk("window flag", 32'h2, q);
    wr(8'h2c, 32'h2);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    conv(10'h011);
    wait_rdy();
    rd(8'h20, q);
    chk("free running", 32'h1, q);
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h1);
    rd(8'h20, q);
    chk("start disabled", 32'h0, q);
    chk("core off", 32'h0, {31'h0, core_en});
    wr(8'h00, 32'h1);
    stby <= 1'b1;
    repeat (3) @(posedge clk);
    chk("standby frozen", 32'h0, {31'h0, core_en});
    wr(8'h00, 32'h81);
    repeat (3) @(posedge clk);
    chk("standby running", 32'h1, {31'h0, core_en});
    stby <= 1'b0;
    end_sim();
  end
endmodule : testbench
